/* File: pkg/gtio_consts.vh */
// Constants for the GPS timing and interface logic
`ifndef GTIO_CONSTS_VH
`define GTIO_CONSTS_VH
// ******************************
// Register offsets (bytes)
// ******************************
`define GTIO_A_CTRL    12'h000
`define GTIO_A_STATUS  12'h004
`define GTIO_A_IRQ     12'h008
`define GTIO_A_MASK    12'h00c
`define GTIO_A_SECS    12'h010
`define GTIO_A_POPSEC  12'h014
`define GTIO_A_POPFRAC 12'h018
`define GTIO_A_POPWID  12'h01c
`define GTIO_A_EVSEC   12'h020
`define GTIO_A_EVFRAC  12'h024
`define GTIO_A_SURVEY  12'h028
// ******************************
// Control fields
// ******************************
`define GTIO_C_FSEL_LO 0
`define GTIO_C_FSEL_HI 2
`define GTIO_C_EVPOL   3
`define GTIO_C_POPPOL  4
`define GTIO_C_POPARM  5
`define GTIO_C_AUTOSV  6
`define GTIO_CTRL_RST  32'h0000_0000
// ******************************
// Frequency selector codes
// ******************************
`define GTIO_F_1K    3'h0
`define GTIO_F_10K   3'h1
`define GTIO_F_100K  3'h2
`define GTIO_F_1M    3'h3
`define GTIO_F_5M    3'h4
`define GTIO_F_10M   3'h5
`define GTIO_F_PPS   3'h6
// ******************************
// Interrupt bits
// ******************************
`define GTIO_I_PPS  0
`define GTIO_I_EV   1
`define GTIO_I_POP  2
`define GTIO_I_OVF  3
`define GTIO_I_SURV 4
// ******************************
// Timing
// ******************************
`define GTIO_PCLK_HZ    50000000
`define GTIO_REF_HZ     10000000
`define GTIO_PPS_FRAC   100
`define GTIO_TICK_NS    100
`define GTIO_SURVEY_CNT 10000
`endif

/* File: tb/gtio_evsrc.sv */
// Event source model driving the external event pin
`timescale 1ns/1ps
module gtio_evsrc (
  input  wire logic pclk,
  input  wire logic pol,
  output logic      ev
);
  logic act_q = 1'b0;
  // Idles at the inactive level; each pulse opens with the active edge
  assign ev = pol ^ act_q;
  task pulse(input int w);
    @(posedge pclk);
    act_q <= 1'b1;
    repeat (w) @(posedge pclk);
    act_q <= 1'b0;
  endtask
endmodule

/* File: tb/gtio_monitor.sv */
// Checker on the ports of the timing block
`timescale 1ns/1ps
module gtio_monitor #(
  parameter CLK_HZ = 50000000
) (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready,
  input wire logic        pslverr, pps_out, pop_out, irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata, stored_ctrl
);
  logic [6:0]  ctrl_q;
  logic [31:0] cnt_q;
  logic [1:0]  age_q;
  logic        ld_q, arm_q, seen_q;
  wire         wr  = psel && penable && pwrite;
  wire         rd  = psel && penable && !pwrite;
  wire         act = pop_out ^ ctrl_q[4];
  wire         up  = age_q == 2'h3;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control mirror, second spacing and pulse arming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 7'h00;
      cnt_q <= 32'h0;
      age_q <= 2'h0;
      {ld_q, arm_q, seen_q} <= 3'b100;
    end else begin
      ld_q <= 1'b0;
      age_q <= up ? age_q : age_q + 2'h1;
      cnt_q <= $rose(pps_out) ? 32'h1 : cnt_q + 32'h1;
      seen_q <= seen_q | $rose(pps_out);
      if (ld_q)
        ctrl_q <= stored_ctrl[6:0] & 7'h5f;
      else if (wr && paddr == 12'h000)
        ctrl_q <= pwdata[6:0] & 7'h5f;
      if (wr && paddr == 12'h000 && pwdata[5])
        arm_q <= 1'b1;
      else if ($fell(act) && up)
        arm_q <= 1'b0;
    end
  end
  property p_ready; psel && penable |-> pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("slow answer");
  property p_unmap; rd && paddr > 12'h028 |-> prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_ctrl; rd && paddr == 12'h000 |-> prdata[4:0] == ctrl_q[4:0]; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback");
  property p_per; $rose(pps_out) && seen_q |-> cnt_q == CLK_HZ; endproperty
  a_per: assert property (p_per) else $error("second spacing");
  property p_len; $fell(pps_out) |-> cnt_q == CLK_HZ / 100; endproperty
  a_len: assert property (p_len) else $error("second pulse width");
  property p_irq; $fell(irq) |-> $past(wr && paddr[11:3] == 9'h001); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");
  property p_popw; $rose(act) && up |-> act [*5]; endproperty
  a_popw: assert property (p_popw) else $error("pulse too short");
  property p_once; $rose(act) && up |-> arm_q; endproperty
  a_once: assert property (p_once) else $error("pulse not armed");
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the timing and interface block
`timescale 1ns/1ps
`include "gtio_consts.vh"
module testbench;
  localparam int CHZ = 10000;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        fix_valid = 0, ev_pol = 0, p, a;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, stored_ctrl = 0, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, pps_out, frequency_selector, pop_out, irq, event_in;
  integer      seed = 32'hf84eb4b0;
  int          bad_count = 0, n_checks = 0, cyc = 0, i, j, k, n, s, f, w, ps, pf, t[$];
  int          fq[6] = '{1000, 10000, 100000, 1000000, 5000000, 10000000};
  gtio_top #(.CLK_HZ(CHZ)) u_gtio_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .fix_valid(fix_valid),
    .stored_ctrl(stored_ctrl), .pps_out(pps_out), .frequency_selector(frequency_selector),
    .pop_out(pop_out), .irq(irq));
  gtio_evsrc u_gtio_evsrc (.pclk(pclk), .pol(ev_pol), .ev(event_in));
  always #10 pclk = ~pclk;
  // Hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      finish_test;
    end
  end
  task finish_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task near(input int g, input int e, input int tol);
    n_checks++;
    if (g > e + tol || g < e - tol) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; read data lands in rd
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the slave; only the hang limit ends a stuck transfer
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  // Wait for the next rising edge of the second pulse
  task pps_edge;
    int m;
    m = 0;
    do begin @(posedge pclk); m++; end while (pps_out !== 1'b0 && m < 3 * CHZ);
    do begin @(posedge pclk); m++; end while (pps_out !== 1'b1 && m < 3 * CHZ);
  endtask
  function logic [31:0] cw(input int fs, input int ep);
    return {25'h0, 3'b001, ep[0], fs[2:0]};
  endfunction
  // Main sequence
  initial begin
    stored_ctrl <= {25'h0, 3'b011, 1'b0, 3'({$random(seed)} % 7)};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b1, 12'h0fc, 32'hffffffff);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `GTIO_A_CTRL, 32'h0);
    chk(rd[6:0], stored_ctrl[6:0] & 7'h5f);
    apb(1'b0, `GTIO_A_STATUS, 32'h0);
    chk(rd[3:0], 32'h1);
    for (i = 0; i < 6; i++) begin
      apb(1'b1, `GTIO_A_CTRL, cw(i, 0));
      repeat (20) @(posedge pclk);
      n = 0;
      p = frequency_selector;
      repeat (2500) begin
        @(posedge pclk);
        n += (frequency_selector === 1'b1 && p === 1'b0);
        p = frequency_selector;
      end
      near(n, fq[i] / 20000, 1);
    end
    apb(1'b1, `GTIO_A_CTRL, cw(6, 0));
    pps_edge;
    repeat (10) @(posedge pclk);
    chk(frequency_selector, 1'b1);
    for (j = 0; j < 2; j++) begin
      apb(1'b1, `GTIO_A_CTRL, cw(5, j));
      ev_pol <= j[0];
      pps_edge;
      apb(1'b1, `GTIO_A_IRQ, 32'h1f);
      t.delete();
      for (i = 0; i < 9 - 6 * j; i++) begin
        w = 2 + {$random(seed)} % 40;
        u_gtio_evsrc.pulse(w);
        t.push_back(cyc - w);
        repeat (30 + {$random(seed)} % 200) @(posedge pclk);
      end
      apb(1'b0, `GTIO_A_STATUS, 32'h0);
      chk(rd[1:0], j ? 32'h0 : 32'h2);
      apb(1'b0, `GTIO_A_IRQ, 32'h0);
      chk(rd[3:1], j ? 32'h1 : 32'h5);
      for (i = 0; i < 8 - 5 * j; i++) begin
        apb(1'b0, `GTIO_A_EVSEC, 32'h0);
        s = rd;
        apb(1'b0, `GTIO_A_EVFRAC, 32'h0);
        if (i > 0) chk(s, ps);
        if (i > 0) near(rd - pf, (t[i] - t[i - 1]) / 5, 1);
        ps = s;
        pf = rd;
      end
      apb(1'b0, `GTIO_A_STATUS, 32'h0);
      chk(rd[0], 1'b1);
    end
    apb(1'b1, `GTIO_A_MASK, 32'h0);
    @(posedge pclk);
    a = irq;
    apb(1'b1, `GTIO_A_MASK, 32'h1f);
    @(posedge pclk);
    chk(a ^ irq, 1'b1);
    apb(1'b1, `GTIO_A_IRQ, 32'h1f);
    apb(1'b0, `GTIO_A_IRQ, 32'h0);
    chk(rd[3:1], 32'h0);
    pps_edge;
    apb(1'b0, `GTIO_A_SECS, 32'h0);
    s = rd;
    f = 100 + {$random(seed)} % 900;
    w = 1 + {$random(seed)} % 60;
    apb(1'b1, `GTIO_A_POPSEC, s + 1);
    apb(1'b1, `GTIO_A_POPFRAC, f);
    apb(1'b1, `GTIO_A_POPWID, w);
    apb(1'b1, `GTIO_A_CTRL, cw(5, 1) | 32'h20);
    chk(pop_out, 1'b1);
    pps_edge;
    for (k = 0; pop_out === 1'b1 && k < CHZ; k++) @(posedge pclk);
    near(k, f * 5, 5);
    for (k = 0; pop_out === 1'b0 && k < CHZ; k++) @(posedge pclk);
    near(k, w * 5, 2);
    apb(1'b0, `GTIO_A_IRQ, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, `GTIO_A_CTRL, cw(5, 1) | 32'h40);
    fix_valid <= 1'b1;
    repeat (9999) @(posedge pclk);
    fix_valid <= 1'b0;
    apb(1'b0, `GTIO_A_STATUS, 32'h0);
    chk(rd[4], 1'b0);
    fix_valid <= 1'b1;
    @(posedge pclk);
    fix_valid <= 1'b0;
    apb(1'b0, `GTIO_A_STATUS, 32'h0);
    chk(rd[4], 1'b1);
    finish_test;
  end
endmodule
bind gtio_top gtio_monitor #(.CLK_HZ(CLK_HZ)) u_gtio_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .pps_out(pps_out), .pop_out(pop_out), .irq(irq), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .stored_ctrl(stored_ctrl));

/* File: verilog/gtio_div.v */
// Coherent divider producing a square wave from the reference tick
`timescale 1ns/1ps
module gtio_div #(
  parameter HALF = 5
) (
  pclk,
  presetn,
  tick,
  sync,
  wave
);
  input             pclk;
  input             presetn;
  input             tick;
  input             sync;
  output reg        wave;
  reg        [23:0] cnt_q;

  // Toggle every HALF reference ticks, realigned on each second pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 24'h000000;
      wave  <= 1'b0;
    end else if (sync) begin
      cnt_q <= 24'h000000;
      wave  <= 1'b1;
    end else if (tick) begin
      if (cnt_q == HALF - 1) begin
        cnt_q <= 24'h000000;
        wave  <= ~wave;
      end else begin
        cnt_q <= cnt_q + 24'h000001;
      end
    end
  end
endmodule

/* File: verilog/gtio_top.v */
// Timing and interface logic: rate output, second pulse, event tags, programmed pulse
`timescale 1ns/1ps
`include "gtio_consts.vh"
module gtio_top #(
  parameter CLK_HZ   = 50000000,
  parameter EV_DEPTH = 8,
  parameter EV_AW    = 3
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        event_in,
  input  wire        fix_valid,
  input  wire [31:0] stored_ctrl,
  output reg         pps_out,
  output reg         frequency_selector,
  output reg         pop_out,
  output wire        irq
);
  // ******************************
  // Reference tick and second
  // ******************************
  // CLK_HZ counts pclk cycles per second; the tick divisor follows the fixed clock
  // ratio, so a shortened second still keeps the 100 ns tick
  localparam TICK_DIV  = `GTIO_PCLK_HZ / `GTIO_REF_HZ;
  localparam SEC_TICKS = CLK_HZ / TICK_DIV;
  localparam PPS_TICKS = SEC_TICKS / `GTIO_PPS_FRAC;
  reg [7:0]  pre_q;
  reg [23:0] frac_q;
  reg [31:0] secs_q;
  // One tick per 100 ns; the second ends on the last tick of the count
  wire tick = (pre_q == TICK_DIV - 1);
  wire sec_end = tick && (frac_q == SEC_TICKS - 1);

  // Reference tick every 100 ns, fraction counter and second count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q  <= 8'h00;
      frac_q <= 24'h000000;
      secs_q <= 32'h0000_0000;
    end else begin
      pre_q <= tick ? 8'h00 : pre_q + 8'h01;
      if (sec_end) begin
        frac_q <= 24'h000000;
        secs_q <= secs_q + 32'h0000_0001;
      end else if (tick) begin
        frac_q <= frac_q + 24'h000001;
      end
    end
  end

  // Second pulse high for the first 10 ms of each second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) pps_out <= 1'b0;
    else pps_out <= (frac_q < PPS_TICKS);
  end

  // ******************************
  // Registers and bus
  // ******************************
  // Writable state; the pulse time and width are lost on reset
  reg [31:0] ctrl_q;
  reg [4:0]  irq_q;
  reg [4:0]  mask_q;
  reg [31:0] pop_sec_q;
  reg [23:0] pop_frac_q;
  reg [23:0] pop_wid_q;
  reg        boot_q;
  // Access phase decode; zero wait, so every access completes in one cycle
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // Rate code from the control word
  wire [2:0] fsel = ctrl_q[`GTIO_C_FSEL_HI:`GTIO_C_FSEL_LO];

  // ******************************
  // Rate output
  // ******************************
  wire w1k, w10k, w100k, w1m, w5m;
  // Decade dividers, all realigned on the second so their edges share its phase
  gtio_div #(.HALF(5000)) u_d1k (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .sync    (sec_end),
    .wave    (w1k)
  );
  gtio_div #(.HALF(500)) u_d10k (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .sync    (sec_end),
    .wave    (w10k)
  );
  gtio_div #(.HALF(50)) u_d100k (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .sync    (sec_end),
    .wave    (w100k)
  );
  gtio_div #(.HALF(5)) u_d1m (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .sync    (sec_end),
    .wave    (w1m)
  );
  reg w5m_q;
  reg w10m_q;
  assign w5m = w5m_q;

  // 10 MHz follows the tick phase, 5 MHz toggles on each tick
  // Both come straight off the tick counter, so no divider instance is needed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w10m_q <= 1'b0;
      w5m_q  <= 1'b0;
    end else begin
      w10m_q <= (pre_q < TICK_DIV / 2);
      if (sec_end) w5m_q <= 1'b1;
      else if (tick) w5m_q <= ~w5m_q;
    end
  end

  // One source per rate code drives the selectable output; the unused code 7 drives it low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) frequency_selector <= 1'b0;
    else begin
      case (fsel)
        `GTIO_F_1K:   frequency_selector <= w1k;
        `GTIO_F_10K:  frequency_selector <= w10k;
        `GTIO_F_100K: frequency_selector <= w100k;
        `GTIO_F_1M:   frequency_selector <= w1m;
        `GTIO_F_5M:   frequency_selector <= w5m;
        `GTIO_F_10M:  frequency_selector <= w10m_q;
        `GTIO_F_PPS:  frequency_selector <= pps_out;
        default:      frequency_selector <= 1'b0;
      endcase
    end
  end

  // ******************************
  // Event time-tagger
  // ******************************
  // Pin level passes three flops; a change counts once the last two agree
  reg [2:0] ev_s_q;
  reg       ev_last_q;
  wire ev_lvl = ev_s_q[2];
  wire ev_agree = (ev_s_q[1] == ev_s_q[2]);
  wire ev_act = ev_lvl ^ ctrl_q[`GTIO_C_EVPOL];
  // An event is a settled level change into the active sense; tracking the
  // level, not the active state, keeps a polarity change from faking an edge
  wire ev_hit = ev_agree && (ev_lvl != ev_last_q) && ev_act;
  reg [55:0] ev_mem [0:EV_DEPTH-1];
  reg [EV_AW:0] wp_q;
  reg [EV_AW:0] rp_q;
  wire ev_empty = (wp_q == rp_q);
  wire ev_full = (wp_q[EV_AW-1:0] == rp_q[EV_AW-1:0]) && (wp_q[EV_AW] != rp_q[EV_AW]);
  // Reading the fraction word retires the head entry
  wire [55:0] ev_head = ev_mem[rp_q[EV_AW-1:0]];
  wire ev_pop = rd && (paddr == `GTIO_A_EVFRAC) && !ev_empty;

  // Three-stage synchroniser and edge of the selected sense
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s_q    <= 3'h0;
      ev_last_q <= 1'b0;
    end else begin
      ev_s_q <= {ev_s_q[1:0], event_in};
      if (ev_agree) ev_last_q <= ev_lvl;
    end
  end

  // Event buffer, full buffer keeps older stamps and flags overflow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= {(EV_AW+1){1'b0}};
      rp_q <= {(EV_AW+1){1'b0}};
    end else begin
      if (ev_hit && !ev_full) wp_q <= wp_q + 1'b1;
      if (ev_pop) rp_q <= rp_q + 1'b1;
    end
  end

  always @(posedge pclk) begin
    if (ev_hit && !ev_full) ev_mem[wp_q[EV_AW-1:0]] <= {secs_q, frac_q};
  end

  // ******************************
  // Programmed pulse
  // ******************************
  // Pulse states: idle, waiting for the set time, driving the pulse
  localparam P_IDLE = 2'd0;
  localparam P_ARM  = 2'd1;
  localparam P_FIRE = 2'd2;
  reg [1:0]  pst_q;
  reg [23:0] pcnt_q;
  // The arm bit is a strobe: it is never kept in the control word
  wire arm_wr = wr && (paddr == `GTIO_A_CTRL) && pwdata[`GTIO_C_POPARM];
  wire pop_done = (pst_q == P_FIRE) && tick && (pcnt_q == pop_wid_q - 24'h000001);

  // Arm, match the second and fraction, hold for the width, then idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_q   <= P_IDLE;
      pcnt_q  <= 24'h000000;
      pop_out <= 1'b0;
    end else begin
      case (pst_q)
        P_IDLE: if (arm_wr) pst_q <= P_ARM;
        P_ARM: begin
          if (tick && secs_q == pop_sec_q && frac_q == pop_frac_q) begin
            pst_q  <= P_FIRE;
            pcnt_q <= 24'h000000;
          end
        end
        P_FIRE: begin
          if (pop_done) pst_q <= P_IDLE;
          else if (tick) pcnt_q <= pcnt_q + 24'h000001;
        end
        default: pst_q <= P_IDLE;
      endcase
      pop_out <= ctrl_q[`GTIO_C_POPPOL] ^ (pst_q == P_FIRE);
    end
  end

  // ******************************
  // Auto-survey
  // ******************************
  // Fix counter for the survey; static mode latches until reset
  reg [13:0] sv_q;
  reg        static_q;
  wire sv_done = ctrl_q[`GTIO_C_AUTOSV] && !static_q && fix_valid &&
                 (sv_q == `GTIO_SURVEY_CNT - 1);

  // Count fixes, then enter static timing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sv_q     <= 14'h0000;
      static_q <= 1'b0;
    end else if (!ctrl_q[`GTIO_C_AUTOSV]) begin
      sv_q <= 14'h0000;
    end else if (sv_done) begin
      static_q <= 1'b1;
    end else if (fix_valid && !static_q) begin
      sv_q <= sv_q + 14'h0001;
    end
  end

  // ******************************
  // Register writes and interrupts
  // ******************************
  // Event sources in interrupt bit order: survey, overflow, pulse, event, second
  wire [4:0] ev_set = {sv_done, ev_hit && ev_full, pop_done, ev_hit, sec_end};

  // Stored configuration loads once after reset; set beats write-one clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `GTIO_CTRL_RST;
      boot_q     <= 1'b1;
      irq_q      <= 5'h00;
      mask_q     <= 5'h00;
      pop_sec_q  <= 32'h0000_0000;
      pop_frac_q <= 24'h000000;
      pop_wid_q  <= 24'h000001;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) ctrl_q <= stored_ctrl & 32'hffff_ffdf;
      else if (wr && paddr == `GTIO_A_CTRL) ctrl_q <= pwdata & 32'hffff_ffdf;
      if (wr && paddr == `GTIO_A_MASK) mask_q <= pwdata[4:0];
      if (wr && paddr == `GTIO_A_POPSEC) pop_sec_q <= pwdata;
      if (wr && paddr == `GTIO_A_POPFRAC) pop_frac_q <= pwdata[23:0];
      if (wr && paddr == `GTIO_A_POPWID) pop_wid_q <= (pwdata[23:0] == 24'h0) ? 24'h1 :
                                                      pwdata[23:0];
      irq_q <= (irq_q & ~((wr && paddr == `GTIO_A_IRQ) ? pwdata[4:0] : 5'h00)) | ev_set;
    end
  end
  // Level interrupt, high while any unmasked status bit is set
  assign irq = |(irq_q & mask_q);

  // Read data mux; unmapped offsets read as zero
  always @* begin
    case (paddr)
      `GTIO_A_CTRL:    prdata = ctrl_q;
      `GTIO_A_STATUS:  prdata = {24'h0, static_q, pst_q, ev_full, ev_empty, 3'h0} >> 3;
      `GTIO_A_IRQ:     prdata = {27'h0, irq_q};
      `GTIO_A_MASK:    prdata = {27'h0, mask_q};
      `GTIO_A_SECS:    prdata = secs_q;
      `GTIO_A_POPSEC:  prdata = pop_sec_q;
      `GTIO_A_POPFRAC: prdata = {8'h0, pop_frac_q};
      `GTIO_A_POPWID:  prdata = {8'h0, pop_wid_q};
      `GTIO_A_EVSEC:   prdata = ev_head[55:24];
      `GTIO_A_EVFRAC:  prdata = {8'h0, ev_head[23:0]};
      `GTIO_A_SURVEY:  prdata = {18'h0, sv_q};
      default:         prdata = 32'h0000_0000;
    endcase
  end
endmodule
